/* include/vout_margin_consts.svh */
// constants for the output-voltage margin and feedback-ratio registers
`ifndef VOUT_MARGIN_CONSTS_SVH
`define VOUT_MARGIN_CONSTS_SVH

// command codes
`define CODE_OPERATION 8'h01
`define CODE_CLEAR_FAULTS 8'h03
`define CODE_STORE_ALL 8'h11
`define CODE_RESTORE_ALL 8'h12
`define CODE_STORE_CODE 8'h13
`define CODE_RESTORE_CODE 8'h14
`define CODE_MARGIN_HIGH 8'h25
`define CODE_MARGIN_LOW 8'h26
`define CODE_FB_RATIO 8'h29

// reset values and writable bits
`define MARGIN_HIGH_RST 16'h0547
`define MARGIN_LOW_RST 16'h0451
`define FB_RATIO_RST 16'hb900
`define MARGIN_WR_MASK 16'h7fff
`define FB_RATIO_WR_MASK 16'h03ff

// operation byte margin field
`define OP_MARGIN_LSB 4
`define OP_MARGIN_MSB 5
`define OP_MARGIN_LOW 2'h1
`define OP_MARGIN_HIGH 2'h2

// ratio mantissa field and fixed exponent (-9)
`define FB_MANT_MSB 10
`define FB_EXP_SHIFT 9
// one quarter of nominal is the 25 percent window
`define MARGIN_WIN_SHIFT 2
// low byte carries the register code for store/restore by code
`define CODE_BYTE_MSB 7

`endif

/* include/vout_margin_pkg.sv */
// types shared by the margin register bank
package vout_margin_pkg;

  typedef enum logic [1:0] {
    ST_NOMINAL,
    ST_MARGIN_LOW,
    ST_MARGIN_HIGH
  } margin_state_t;

  // one decoded command from the bus interface core
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } pmbus_cmd_t;

  // read answer
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } pmbus_rsp_t;

  // fault flags
  typedef struct packed {
    logic cml;
    logic ivd;
  } cml_status_t;

endpackage

/* tb/pmbus_host_model.sv */
// host model issuing single-word commands to the register bank
module pmbus_host_model (
  input wire logic clk_in, // system clock
  input vout_margin_pkg::pmbus_rsp_t rsp_in, // read answer
  output vout_margin_pkg::pmbus_cmd_t cmd_out // command
);
  timeunit 1ns;
  timeprecision 1ps;
  import vout_margin_pkg::*;
  initial cmd_out = '0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] rd);
    @(posedge clk_in);
    #1 cmd_out = '{valid: 1'b1, write: w, code: c, data: d};
    @(posedge clk_in);
    // released fields show inverted values, never the stale ones
    #1 cmd_out = '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
    rd = rsp_in.valid ? rsp_in.data : 16'hdead;
  endtask
endmodule

/* tb/vout_margin_props.sv */
// port assertions for the margin and feedback-ratio register bank
module vout_margin_props (
  input wire logic clk_in, // system clock
  input wire logic nrst_in, // synchronous reset, active low
  input vout_margin_pkg::pmbus_cmd_t cmd_in, // command
  input vout_margin_pkg::pmbus_rsp_t rsp_out, // read answer
  input vout_margin_pkg::cml_status_t status_out, // fault flags
  input vout_margin_pkg::margin_state_t state_out // selected state
);
  import vout_margin_pkg::*;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic op_w;
  logic clr_w;
  logic rd_w;
  logic wm_w;
  assign op_w = cmd_in.valid && cmd_in.write && cmd_in.code == 8'h01;
  assign clr_w = cmd_in.valid && cmd_in.write && cmd_in.code == 8'h03;
  assign rd_w = cmd_in.valid && !cmd_in.write;
  assign wm_w = cmd_in.valid && cmd_in.write && (cmd_in.code == 8'h25 || cmd_in.code == 8'h26);
  a_high_select: assert property (
    op_w && cmd_in.data[5:4] == 2'h2 |=> state_out == ST_MARGIN_HIGH)
    else $error("state not margin high after operation");
  a_low_select: assert property (
    op_w && cmd_in.data[5:4] == 2'h1 |=> state_out == ST_MARGIN_LOW)
    else $error("state not margin low after operation");
  a_write_quiet: assert property (
    wm_w && status_out == '0 |=> status_out == '0)
    else $error("flags raised by a margin write");
  a_check_on_op: assert property (
    $rose(status_out.ivd) |-> $past(op_w))
    else $error("flag raised without an operation");
  a_flags_sticky: assert property (
    status_out.cml && !clr_w |=> status_out.cml)
    else $error("flag dropped without clear");
  a_flags_paired: assert property (
    status_out.cml == status_out.ivd)
    else $error("cml and invalid-data flags differ");
  a_flags_clear: assert property (
    clr_w |=> !status_out.cml && !status_out.ivd)
    else $error("flags not cleared");
  a_read_answer: assert property (
    rd_w |=> rsp_out.valid ##1 !rsp_out.valid || $past(rd_w))
    else $error("read answer missing or long");
  a_state_cause: assert property (
    state_out != $past(state_out) |-> $past(op_w))
    else $error("state changed without operation");
endmodule

bind vout_margin_scale_registers vout_margin_props u_props (.clk_in(clk_in),
  .nrst_in(nrst_in), .cmd_in(cmd_in), .rsp_out(rsp_out), .status_out(status_out),
  .state_out(state_out));

/* tb/vout_margin_scale_registers_test.sv */
// self-checking bench for the margin and feedback-ratio register bank
module vout_margin_scale_registers_test;
  timeunit 1ns;
  timeprecision 1ps;
  import vout_margin_pkg::*;
  logic clk_in;
  logic nrst_in;
  logic signed [15:0] trim_in;
  logic [15:0] nominal_in;
  logic [15:0] vout_cmd_out;
  logic [15:0] vref_cmd_out;
  logic [15:0] rd;
  pmbus_cmd_t cmd_in;
  pmbus_rsp_t rsp_out;
  cml_status_t status_out;
  margin_state_t state_out;
  int fail_count = 0;
  int compares = 0;
  vout_margin_scale_registers DUT (.clk_in(clk_in), .nrst_in(nrst_in), .cmd_in(cmd_in),
    .trim_in(trim_in), .nominal_in(nominal_in), .rsp_out(rsp_out),
    .status_out(status_out), .state_out(state_out), .vout_cmd_out(vout_cmd_out),
    .vref_cmd_out(vref_cmd_out));
  pmbus_host_model host (.clk_in(clk_in), .rsp_in(rsp_out), .cmd_out(cmd_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic report_and_stop();
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.xfer(1'b1, c, d, rd);
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
    host.xfer(1'b0, c, 16'h0000, rd);
    cmp_word(exp, rd);
  endtask
  // operation, then state and flags after one edge, outputs after two
  task automatic op(input logic [1:0] m, input margin_state_t s, input logic [1:0] f,
                    input logic [15:0] v, input logic [15:0] r);
    wr(8'h01, {10'h000, m, 4'h0});
    cmp_word(16'(s), 16'(state_out));
    cmp_word({14'h0000, f}, 16'(status_out));
    @(posedge clk_in);
    #1;
    cmp_word(v, vout_cmd_out);
    cmp_word(r, vref_cmd_out);
  endtask
  initial begin
    nrst_in = 1'b0;
    trim_in = 16'sh0010;
    nominal_in = 16'h04cd;
    repeat (16) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    rchk(8'h25, 16'h0547);
    rchk(8'h26, 16'h0451);
    rchk(8'h29, 16'hb900);
    rchk(8'h20, 16'h0000);
    wr(8'h25, 16'hffff);
    rchk(8'h25, 16'h7fff);
    cmp_word(16'h0000, 16'(status_out));
    wr(8'h29, 16'hffff);
    rchk(8'h29, 16'hbbff);
    wr(8'h12, 16'h0000);
    rchk(8'h25, 16'h0547);
    rchk(8'h29, 16'hb900);
    wr(8'h29, 16'h0100);
    op(2'h2, ST_MARGIN_HIGH, 2'b00, 16'h0557, 16'h02ab);
    op(2'h1, ST_MARGIN_LOW, 2'b00, 16'h0461, 16'h0230);
    op(2'h0, ST_NOMINAL, 2'b00, 16'h04dd, 16'h026e);
    wr(8'h25, 16'h05fa);
    op(2'h2, ST_MARGIN_HIGH, 2'b00, 16'h060a, 16'h0305);
    wr(8'h25, 16'h0700);
    cmp_word(16'h0000, 16'(status_out));
    op(2'h2, ST_MARGIN_HIGH, 2'b11, 16'h0610, 16'h0308);
    wr(8'h03, 16'h0000);
    cmp_word(16'h0000, 16'(status_out));
    wr(8'h26, 16'h0100);
    wr(8'h29, 16'h0200);
    op(2'h1, ST_MARGIN_LOW, 2'b11, 16'h03aa, 16'h03aa);
    wr(8'h13, 16'h0025);
    wr(8'h25, 16'h0123);
    wr(8'h14, 16'h0025);
    rchk(8'h25, 16'h0700);
    wr(8'h14, 16'h0026);
    rchk(8'h26, 16'h0451);
    wr(8'h26, 16'h0333);
    wr(8'h11, 16'h0000);
    wr(8'h26, 16'h0222);
    wr(8'h12, 16'h0000);
    rchk(8'h26, 16'h0333);
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge clk_in);
    fail_count++;
    report_and_stop();
  end
endmodule

/* verilog/linear_word_reg.sv */
// one command register with writable-bit mask and a non-volatile default copy
`include "vout_margin_consts.svh"

module linear_word_reg #(
  parameter int WORD_W = 16,
  parameter logic [WORD_W-1:0] RST_VAL = '0,
  parameter logic [WORD_W-1:0] WR_MASK = '1
) (
  input wire logic clk_in, // system clock
  input wire logic nrst_in, // synchronous reset, active low
  input wire logic wr_in, // host write
  input wire logic [WORD_W-1:0] wr_data_in, // host write data
  input wire logic store_in, // copy live value into default store
  input wire logic restore_in, // copy default store into live value
  output logic [WORD_W-1:0] value_out // live value
);

  if (WORD_W != 16) begin : g_chk
    $error("linear_word_reg serves 16-bit words only");
  end

  typedef struct packed {
    logic [WORD_W-1:0] live;
    logic [WORD_W-1:0] nv;
  } reg_state_t;

  reg_state_t state_r;
  reg_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    // fixed bits keep their reset value, writable bits take host data
    if (wr_in) begin
      state_nxt.live = (wr_data_in & WR_MASK) | (RST_VAL & ~WR_MASK);
    end else if (restore_in) begin
      state_nxt.live = state_r.nv;
    end
    if (store_in) begin
      state_nxt.nv = state_r.live;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= '{live: RST_VAL, nv: RST_VAL};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign value_out = state_r.live;

endmodule

/* verilog/margin_range_check.sv */
// compares a margin value with the 25 percent window around nominal and clamps it
`include "vout_margin_consts.svh"

module margin_range_check #(
  parameter int WORD_W = 16
) (
  input wire logic [WORD_W-1:0] margin_in, // requested margin value
  input wire logic [WORD_W-1:0] nominal_in, // nominal output, trim excluded
  output logic [WORD_W:0] clamped_out, // value to apply
  output logic over_out, // above upper limit
  output logic under_out // below lower limit
);

  if (WORD_W < 4) begin : g_chk
    $error("margin_range_check needs at least 4 bits");
  end

  logic [WORD_W:0] quarter;
  logic [WORD_W:0] hi_lim;
  logic [WORD_W:0] lo_lim;
  logic [WORD_W:0] req;

  always_comb begin
    quarter = {1'b0, nominal_in} >> `MARGIN_WIN_SHIFT;
    hi_lim = {1'b0, nominal_in} + quarter;
    lo_lim = {1'b0, nominal_in} - quarter;
    req = {1'b0, margin_in};
    over_out = req > hi_lim;
    under_out = req < lo_lim;
    if (over_out) begin
      clamped_out = hi_lim;
    end else if (under_out) begin
      clamped_out = lo_lim;
    end else begin
      clamped_out = req;
    end
  end

endmodule

/* verilog/vout_margin_scale_registers.sv */
// margin-high, margin-low and feedback-ratio command registers with margin selection
//
// Notes on behaviour
// - margin-high state steers the output target to the margin-high register (25h)
// - margin-low state steers the output target to the margin-low register (26h)
// - margin values are linear, exponent -10; target is margin plus trim
// - margin register writes are stored unchecked and raise no status
// - range check happens only when an operation command selects a margin state
// - out-of-window margin sets cml in status byte and invalid-data flag
// - out-of-window margin still applies, clamped to the exceeded limit
// - window is 25 percent of nominal alone, trim offset excluded
// - margin-high register resets to 0x547
// - margin-low register resets to 0x451
// - store-all, or store-by-code naming a register, copies it to default store
// - restore-all, or restore-by-code naming a register, reloads its default
// - feedback ratio (29h) defaults to 0.5
// - ratio upper six bits are read-only, lower ten mantissa bits writable
// - only the reference result (vref) is scaled by the feedback ratio; the vout result is not
// - ratio exponent fixed at -9; mantissa 256 means 0.5
`include "vout_margin_consts.svh"

module vout_margin_scale_registers #(
  parameter int WORD_W = 16
) (
  input wire logic clk_in, // system clock, 25 MHz
  input wire logic nrst_in, // synchronous reset, active low
  input vout_margin_pkg::pmbus_cmd_t cmd_in, // decoded command from bus core
  input wire logic signed [WORD_W-1:0] trim_in, // trim offset, 2^-10 volt units
  input wire logic [WORD_W-1:0] nominal_in, // nominal output, 2^-10 volt units
  output vout_margin_pkg::pmbus_rsp_t rsp_out, // read answer
  output vout_margin_pkg::cml_status_t status_out, // cml and invalid-data flags
  output vout_margin_pkg::margin_state_t state_out, // selected output state
  output logic [WORD_W-1:0] vout_cmd_out, // commanded output, 2^-10 volt units
  output logic [WORD_W-1:0] vref_cmd_out // commanded reference after ratio
);
  import vout_margin_pkg::*;

  if (WORD_W != 16) begin : g_chk
    $error("vout_margin_scale_registers serves 16-bit words only");
  end

  // a zero shift would make the window as wide as nominal itself
  if (`MARGIN_WIN_SHIFT < 1) begin : g_win_chk
    $error("vout_margin_scale_registers needs a window narrower than nominal");
  end

  localparam int PROD_W = WORD_W + 3 + `FB_MANT_MSB + 1;

  typedef struct packed {
    pmbus_rsp_t rsp;
    cml_status_t status;
    margin_state_t state;
    logic [WORD_W:0] applied;
    logic [WORD_W-1:0] vout;
    logic [WORD_W-1:0] vref;
  } top_state_t;

  top_state_t state_r;
  top_state_t state_nxt;

  logic [WORD_W-1:0] hi_val;
  logic [WORD_W-1:0] lo_val;
  logic [WORD_W-1:0] ratio_val;
  logic wr_cmd;
  logic [1:0] op_margin;
  logic [7:0] code_sel;
  logic store_all;
  logic restore_all;
  logic store_code;
  logic restore_code;
  logic hi_wr;
  logic lo_wr;
  logic ratio_wr;
  logic hi_store;
  logic lo_store;
  logic ratio_store;
  logic hi_restore;
  logic lo_restore;
  logic ratio_restore;
  logic hi_bad;
  logic lo_bad;
  logic [WORD_W-1:0] rd_data;
  logic [WORD_W:0] hi_clamped;
  logic hi_over;
  logic hi_under;
  logic [WORD_W:0] lo_clamped;
  logic lo_over;
  logic lo_under;
  logic signed [WORD_W+2:0] target;
  logic signed [WORD_W+2:0] target_pos;
  logic signed [`FB_MANT_MSB:0] mant;
  logic signed [PROD_W-1:0] product;
  logic [PROD_W-1:0] scaled;

  // command decode
  always_comb begin
    wr_cmd = cmd_in.valid && cmd_in.write;
    op_margin = cmd_in.data[`OP_MARGIN_MSB:`OP_MARGIN_LSB];
    code_sel = cmd_in.data[`CODE_BYTE_MSB:0];
    store_all = wr_cmd && (cmd_in.code == `CODE_STORE_ALL);
    restore_all = wr_cmd && (cmd_in.code == `CODE_RESTORE_ALL);
    store_code = wr_cmd && (cmd_in.code == `CODE_STORE_CODE);
    restore_code = wr_cmd && (cmd_in.code == `CODE_RESTORE_CODE);
    // writes land without any range check
    // unchecked margin and ratio writes
    hi_wr = wr_cmd && (cmd_in.code == `CODE_MARGIN_HIGH);
    lo_wr = wr_cmd && (cmd_in.code == `CODE_MARGIN_LOW);
    ratio_wr = wr_cmd && (cmd_in.code == `CODE_FB_RATIO);
    // store by code picks one register
    hi_store = store_all || (store_code && code_sel == `CODE_MARGIN_HIGH);
    lo_store = store_all || (store_code && code_sel == `CODE_MARGIN_LOW);
    ratio_store = store_all || (store_code && code_sel == `CODE_FB_RATIO);
    // restore by code picks one register
    hi_restore = restore_all || (restore_code && code_sel == `CODE_MARGIN_HIGH);
    lo_restore = restore_all || (restore_code && code_sel == `CODE_MARGIN_LOW);
    ratio_restore = restore_all || (restore_code && code_sel == `CODE_FB_RATIO);
  end

  // read data mux, unknown codes answer zero
  always_comb begin
    unique case (cmd_in.code)
      `CODE_MARGIN_HIGH: rd_data = hi_val;
      `CODE_MARGIN_LOW: rd_data = lo_val;
      `CODE_FB_RATIO: rd_data = ratio_val;
      default: rd_data = '0;
    endcase
  end

  linear_word_reg #(
    .WORD_W(WORD_W),
    .RST_VAL(`MARGIN_HIGH_RST),
    .WR_MASK(`MARGIN_WR_MASK)
  ) u_margin_high (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .wr_in(hi_wr),
    .wr_data_in(cmd_in.data),
    .store_in(hi_store),
    .restore_in(hi_restore),
    .value_out(hi_val)
  );

  linear_word_reg #(
    .WORD_W(WORD_W),
    .RST_VAL(`MARGIN_LOW_RST),
    .WR_MASK(`MARGIN_WR_MASK)
  ) u_margin_low (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .wr_in(lo_wr),
    .wr_data_in(cmd_in.data),
    .store_in(lo_store),
    .restore_in(lo_restore),
    .value_out(lo_val)
  );

  linear_word_reg #(
    .WORD_W(WORD_W),
    .RST_VAL(`FB_RATIO_RST),
    .WR_MASK(`FB_RATIO_WR_MASK)
  ) u_fb_ratio (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .wr_in(ratio_wr),
    .wr_data_in(cmd_in.data),
    .store_in(ratio_store),
    .restore_in(ratio_restore),
    .value_out(ratio_val)
  );

  margin_range_check #(
    .WORD_W(WORD_W)
  ) u_check_high (
    .margin_in(hi_val),
    .nominal_in(nominal_in),
    .clamped_out(hi_clamped),
    .over_out(hi_over),
    .under_out(hi_under)
  );

  margin_range_check #(
    .WORD_W(WORD_W)
  ) u_check_low (
    .margin_in(lo_val),
    .nominal_in(nominal_in),
    .clamped_out(lo_clamped),
    .over_out(lo_over),
    .under_out(lo_under)
  );

  // out of window on either side
  always_comb begin
    hi_bad = hi_over || hi_under;
    lo_bad = lo_over || lo_under;
  end

  // the target carries three guard bits so that trim cannot wrap it;
  // the product is wide enough for a full eleven-bit mantissa, so the
  // saturation below only trips for ratios the host should never program

  // output target arithmetic on the registered state
  always_comb begin
    if (state_r.state == ST_NOMINAL) begin
      target = $signed({3'b000, nominal_in}) + (WORD_W+3)'(trim_in);
    end else begin
      target = $signed({2'b00, state_r.applied}) + (WORD_W+3)'(trim_in);
    end
    // a negative target cannot be regulated, floor it at zero
    target_pos = target[WORD_W+2] ? '0 : target;
    mant = $signed(ratio_val[`FB_MANT_MSB:0]);
    product = PROD_W'(target_pos) * PROD_W'(mant);
    scaled = PROD_W'(product >>> `FB_EXP_SHIFT);
  end

  // state update
  always_comb begin
    state_nxt = state_r;
    state_nxt.rsp.valid = 1'b0;

    if (cmd_in.valid && !cmd_in.write) begin
      state_nxt.rsp.valid = 1'b1;
      state_nxt.rsp.data = rd_data;
    end

    if (wr_cmd && cmd_in.code == `CODE_CLEAR_FAULTS) begin
      state_nxt.status = '0;
    end

    if (wr_cmd && cmd_in.code == `CODE_OPERATION) begin
      unique case (op_margin)
        `OP_MARGIN_HIGH: begin
          state_nxt.state = ST_MARGIN_HIGH;
          state_nxt.applied = hi_clamped;
          if (hi_bad) begin
            state_nxt.status = '{cml: 1'b1, ivd: 1'b1};
          end
        end
        `OP_MARGIN_LOW: begin
          state_nxt.state = ST_MARGIN_LOW;
          state_nxt.applied = lo_clamped;
          if (lo_bad) begin
            state_nxt.status = '{cml: 1'b1, ivd: 1'b1};
          end
        end
        default: begin
          state_nxt.state = ST_NOMINAL;
        end
      endcase
    end

    // saturate into the output word
    if (|target_pos[WORD_W+2:WORD_W]) begin
      state_nxt.vout = '1;
    end else begin
      state_nxt.vout = target_pos[WORD_W-1:0];
    end
    if (|scaled[PROD_W-1:WORD_W]) begin
      state_nxt.vref = '1;
    end else begin
      state_nxt.vref = scaled[WORD_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= '{
        rsp: '0,
        status: '0,
        state: ST_NOMINAL,
        applied: '0,
        vout: '0,
        vref: '0
      };
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rsp_out = state_r.rsp;
  assign status_out = state_r.status;
  assign state_out = state_r.state;
  assign vout_cmd_out = state_r.vout;
  assign vref_cmd_out = state_r.vref;

endmodule
